// ---- verilog/lwm_pkg.sv ----
// Constants, register map and types for the lockup watchdog manageability block
package lwm_pkg;
	localparam int          ADDR_W         = 5;
	localparam logic [4:0]  OFF_CTRL       = 5'h00;
	localparam logic [4:0]  OFF_RELOAD     = 5'h04;
	localparam logic [4:0]  OFF_SERVICE    = 5'h08;
	localparam logic [4:0]  OFF_COUNT      = 5'h0c;
	localparam logic [4:0]  OFF_STATUS     = 5'h10;
	localparam logic [4:0]  OFF_MASK       = 5'h14;
	localparam logic [4:0]  OFF_MGMT       = 5'h18;
	// Control fields
	localparam int          CTRL_TMR_EN    = 0;
	localparam int          CTRL_INTR_LW   = 1;
	localparam int          CTRL_BOOT_EN   = 2;
	localparam int          CTRL_FDIS_LO   = 3;
	localparam int          NUM_FUNC       = 5;
	localparam logic [7:0]  CTRL_RST       = 8'h05;
	localparam logic [15:0] RELOAD_RST     = 16'h0040;
	// Status and mask bits
	localparam int          ST_FIRST       = 0;
	localparam int          ST_SECOND      = 1;
	localparam int          ST_INTRUDER    = 2;
	localparam int          ST_THERMAL     = 3;
	localparam int          ST_NO_BOOT     = 4;
	localparam int          ST_ECC         = 5;
	localparam int          ST_MGMT_RST    = 6;
	localparam int          ST_MGMT_MSG    = 7;
	localparam int          ST_W           = 8;
	// Memory hub message codes
	localparam logic [1:0]  ECC_SMI        = 2'h1;
	localparam logic [1:0]  ECC_ACPI       = 2'h2;
	localparam logic [1:0]  ECC_SERR       = 2'h3;
	// Timing
	localparam int          CLK_NS         = 5;
	localparam int          TICK_NS        = 1000;
	localparam int          TICK_CYC       = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int          LINK_HALF_NS   = 50;
	localparam int          LINK_HALF_CYC  = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [15:0] ALERT_MSG      = 16'ha55a;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {BOOT_WAIT, BOOT_OK, BOOT_BLINK} lwm_boot_type;
	typedef enum logic {LINK_IDLE, LINK_SEND} lwm_link_type;
endpackage

// ---- verilog/lwm_top.sv ----
// Lockup watchdog, boot monitor and manageability event logic with AXI4-Lite registers
// What this block does
// - First lockup timer expiry raises a system management interrupt.
// - Second expiry without servicing drives a full system reset.
// - After reset, watch for the first instruction fetch as proof of boot.
// - Missing fetch blinks a GPIO and reboots with lowest frequency multiplier.
// - Case-open input raises management or lockup-watch interrupt per selection.
// - Disabled functions stop decoding I/O, memory and configuration accesses.
// - Disabled functions produce no interrupts or power management events.
// - Memory hub error message selects management, ACPI or system error interrupt.
// - Lockup-watch events send a fixed alert message on the side link.
// - External controller reads power state, timer, status; may request reset.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module lwm_top
	import lwm_pkg::*;
#(
	parameter int BOOT_TICKS    = 16,
	parameter int BLINK_TICKS   = 8,
	parameter int BLINK_TOGGLES = 6
)(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	// AXI4-Lite slave
	input  wire logic [lwm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [lwm_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Platform pins, asynchronous
	input  wire logic                    case_open_n,
	input  wire logic                    thermal_event,
	input  wire logic                    first_fetch,
	input  wire logic                    ecc_msg_valid,
	input  wire logic [1:0]              ecc_msg_code,
	input  wire logic [1:0]              sys_power_state,
	// Management bus slave view, asynchronous
	input  wire logic [1:0]              mgmt_sel,
	input  wire logic                    mgmt_reset_req,
	input  wire logic                    mgmt_msg_req,
	output logic [15:0]                  mgmt_rd_data,
	// Function gating, same clock
	input  wire logic [lwm_pkg::NUM_FUNC-1:0] func_decode_hit,
	input  wire logic [lwm_pkg::NUM_FUNC-1:0] func_irq,
	input  wire logic [lwm_pkg::NUM_FUNC-1:0] func_pme,
	output logic [lwm_pkg::NUM_FUNC-1:0] func_decode_en,
	output logic                         func_irq_out,
	output logic                         func_pme_out,
	// System outputs
	output logic                         system_mgmt_interrupt,
	output logic                         acpi_control_interrupt,
	output logic                         serr_out,
	output logic                         lockup_watch_irq,
	output logic                         sys_reset_out,
	output logic                         gpio_blink,
	output logic                         min_mult_sel,
	output logic                         irq,
	// Management side link
	output logic                         mgmt_side_link_clk,
	output logic                         mgmt_side_link_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// Register state
	logic [7:0]          ctrl_ff;
	logic [15:0]         reload_ff;
	logic [15:0]         count_ff;
	logic [ST_W-1:0]     status_ff;
	logic [ST_W-1:0]     mask_ff;
	logic                first_exp_ff;
	logic                tick_ff;
	logic [7:0]          tick_cnt_ff;
	logic [11:0]         sync1_ff;
	logic [11:0]         sync2_ff;
	logic [5:0]          last_ff;
	logic [ST_W-1:0]     st_set;
	logic [ST_W-1:0]     st_clr;
	logic                wr_go;
	logic                rd_go;
	logic                svc_wr;
	logic                expire;
	logic                boot_fail;
	logic                reboot;
	lwm_boot_type        boot_ff;
	logic [15:0]         boot_cnt_ff;
	logic [7:0]          blink_cnt_ff;
	lwm_link_type        link_ff;
	logic [7:0]          link_div_ff;
	logic [3:0]          link_bit_ff;
	logic [15:0]         link_sh_ff;
	logic                alert_pend_ff;
	logic [NUM_FUNC-1:0] fdis;
	logic                intr_edge;
	logic                therm_edge;
	logic                ecc_edge;
	logic                mrst_edge;
	logic                mmsg_edge;
	logic                fetch_seen;
	logic                lw_event;

	assign fdis       = ctrl_ff[CTRL_FDIS_LO +: NUM_FUNC];
	assign intr_edge  = ~sync2_ff[0] & last_ff[0];
	assign therm_edge = sync2_ff[1] & ~last_ff[1];
	assign fetch_seen = sync2_ff[2];
	assign ecc_edge   = sync2_ff[3] & ~last_ff[3];
	assign mrst_edge  = sync2_ff[4] & ~last_ff[4];
	assign mmsg_edge  = sync2_ff[5] & ~last_ff[5];
	assign wr_go      = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	assign rd_go      = s_axi_arready & s_axi_arvalid;
	assign svc_wr     = wr_go && s_axi_awaddr == OFF_SERVICE;
	assign expire     = tick_ff && ctrl_ff[CTRL_TMR_EN] && count_ff == 16'h0000;
	assign boot_fail  = boot_ff == BOOT_WAIT && tick_ff && boot_cnt_ff == 16'(BOOT_TICKS - 1) && !fetch_seen;
	assign reboot     = boot_ff == BOOT_BLINK && tick_ff && blink_cnt_ff == 8'(BLINK_TOGGLES * BLINK_TICKS - 1);
	assign lw_event   = (intr_edge && ctrl_ff[CTRL_INTR_LW]) || therm_edge || boot_fail;

	// Pins cross in through two flops; case-open is active low, so idle level is one
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sync1_ff <= 12'h001;
			sync2_ff <= 12'h001;
			last_ff  <= 6'h01;
		end
		else
		begin
			sync1_ff <= {sys_power_state, mgmt_sel, ecc_msg_code, mgmt_msg_req, mgmt_reset_req,
				ecc_msg_valid, first_fetch, thermal_event, case_open_n};
			sync2_ff <= sync1_ff;
			last_ff  <= sync2_ff[5:0];
		end
	end

	// Timebase for the lockup timer and boot monitor
	always_ff @(posedge core_clk)
	begin
		if (reset || tick_cnt_ff == 8'(TICK_CYC - 1))
			tick_cnt_ff <= 8'h00;
		else
			tick_cnt_ff <= tick_cnt_ff + 8'h01;
		tick_ff <= !reset && tick_cnt_ff == 8'(TICK_CYC - 1);
	end

	// Lockup timer
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			count_ff     <= RELOAD_RST;
			first_exp_ff <= 1'b0;
		end
		else if (svc_wr || !ctrl_ff[CTRL_TMR_EN])
		begin
			count_ff     <= reload_ff;
			first_exp_ff <= 1'b0;
		end
		else if (expire)
		begin
			count_ff     <= reload_ff;
			first_exp_ff <= !first_exp_ff;
		end
		else if (tick_ff)
			count_ff <= count_ff - 16'h0001;
	end

	// Boot presence monitor; min multiplier survives the system reboot it causes
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			boot_ff      <= BOOT_WAIT;
			boot_cnt_ff  <= 16'h0000;
			blink_cnt_ff <= 8'h00;
			gpio_blink   <= 1'b0;
			min_mult_sel <= 1'b0;
		end
		else
		begin
			unique case (boot_ff)
				BOOT_WAIT:
				begin
					if (!ctrl_ff[CTRL_BOOT_EN] || fetch_seen)
						boot_ff <= BOOT_OK;
					else if (boot_fail)
					begin
						boot_ff      <= BOOT_BLINK;
						blink_cnt_ff <= 8'h00;
					end
					else if (tick_ff)
						boot_cnt_ff <= boot_cnt_ff + 16'h0001;
				end
				BOOT_OK:
					boot_ff <= BOOT_OK;
				BOOT_BLINK:
				begin
					if (reboot)
					begin
						boot_ff      <= BOOT_WAIT;
						boot_cnt_ff  <= 16'h0000;
						gpio_blink   <= 1'b0;
						min_mult_sel <= 1'b1;
					end
					else if (tick_ff)
					begin
						blink_cnt_ff <= blink_cnt_ff + 8'h01;
						if (blink_cnt_ff % 8'(BLINK_TICKS) == 8'(BLINK_TICKS - 1))
							gpio_blink <= !gpio_blink;
					end
				end
			endcase
		end
	end

	// Event outputs, each a one-cycle pulse
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			system_mgmt_interrupt  <= 1'b0;
			acpi_control_interrupt <= 1'b0;
			serr_out               <= 1'b0;
			lockup_watch_irq       <= 1'b0;
			sys_reset_out          <= 1'b0;
		end
		else
		begin
			system_mgmt_interrupt  <= (expire && !first_exp_ff)
				|| (intr_edge && !ctrl_ff[CTRL_INTR_LW])
				|| (ecc_edge && sync2_ff[7:6] == ECC_SMI);
			acpi_control_interrupt <= ecc_edge && sync2_ff[7:6] == ECC_ACPI;
			serr_out               <= ecc_edge && sync2_ff[7:6] == ECC_SERR;
			lockup_watch_irq       <= intr_edge && ctrl_ff[CTRL_INTR_LW];
			sys_reset_out          <= (expire && first_exp_ff && !svc_wr) || reboot || mrst_edge;
		end
	end

	// Function disable gating
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			func_decode_en <= '0;
			func_irq_out   <= 1'b0;
			func_pme_out   <= 1'b0;
		end
		else
		begin
			func_decode_en <= func_decode_hit & ~fdis;
			func_irq_out   <= |(func_irq & ~fdis);
			func_pme_out   <= |(func_pme & ~fdis);
		end
	end

	// Alert message on the side link; the block drives the link clock from a divider
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			link_ff             <= LINK_IDLE;
			link_div_ff         <= 8'h00;
			link_bit_ff         <= 4'h0;
			link_sh_ff          <= 16'h0000;
			alert_pend_ff       <= 1'b0;
			mgmt_side_link_clk  <= 1'b0;
			mgmt_side_link_data <= 1'b0;
		end
		else
		begin
			link_div_ff <= (link_ff == LINK_IDLE || link_div_ff == 8'(LINK_HALF_CYC - 1)) ? 8'h00
				: link_div_ff + 8'h01;
			unique case (link_ff)
				LINK_IDLE:
				begin
					// Starting a message consumes the queued request and any event of this cycle
					alert_pend_ff <= 1'b0;
					if (alert_pend_ff || lw_event)
					begin
						link_ff             <= LINK_SEND;
						link_sh_ff          <= {ALERT_MSG[14:0], 1'b0};
						mgmt_side_link_data <= ALERT_MSG[15];
						link_bit_ff         <= 4'h0;
					end
				end
				LINK_SEND:
				begin
					// Events during a message are queued for one more message, not counted
					alert_pend_ff <= alert_pend_ff | lw_event;
					if (link_div_ff == 8'(LINK_HALF_CYC - 1))
					begin
						mgmt_side_link_clk <= !mgmt_side_link_clk;
						if (mgmt_side_link_clk)
						begin
							link_sh_ff          <= {link_sh_ff[14:0], 1'b0};
							mgmt_side_link_data <= link_sh_ff[15];
							link_bit_ff         <= link_bit_ff + 4'h1;
							if (link_bit_ff == 4'hf)
							begin
								link_ff             <= LINK_IDLE;
								mgmt_side_link_data <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end

	// Management bus view
	always_ff @(posedge core_clk)
	begin
		if (reset)
			mgmt_rd_data <= 16'h0000;
		else
		begin
			unique case (sync2_ff[9:8])
				2'h0: mgmt_rd_data <= {14'h0000, sync2_ff[11:10]};
				2'h1: mgmt_rd_data <= count_ff;
				2'h2: mgmt_rd_data <= {8'h00, status_ff};
				2'h3: mgmt_rd_data <= {13'h0000, min_mult_sel, boot_ff == BOOT_OK, first_exp_ff};
			endcase
		end
	end

	// Sticky status: a set in the same cycle as the clearing read wins
	always_comb
	begin
		st_set              = '0;
		st_set[ST_FIRST]    = expire && !first_exp_ff;
		st_set[ST_SECOND]   = expire && first_exp_ff && !svc_wr;
		st_set[ST_INTRUDER] = intr_edge;
		st_set[ST_THERMAL]  = therm_edge;
		st_set[ST_NO_BOOT]  = boot_fail;
		st_set[ST_ECC]      = ecc_edge;
		st_set[ST_MGMT_RST] = mrst_edge;
		st_set[ST_MGMT_MSG] = mmsg_edge;
		st_clr              = (rd_go && s_axi_araddr == OFF_STATUS) ? '1 : '0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			status_ff <= '0;
			irq       <= 1'b0;
		end
		else
		begin
			status_ff <= (status_ff & ~st_clr) | st_set;
			irq       <= |(status_ff & mask_ff);
		end
	end

	// AXI4-Lite write path; address and data are taken together
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			ctrl_ff       <= CTRL_RST;
			reload_ff     <= RELOAD_RST;
			mask_ff       <= '0;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				unique case (s_axi_awaddr)
					OFF_CTRL:
						if (s_axi_wstrb[0])
							ctrl_ff <= s_axi_wdata[7:0];
					OFF_RELOAD:
					begin
						if (s_axi_wstrb[0])
							reload_ff[7:0] <= s_axi_wdata[7:0];
						if (s_axi_wstrb[1])
							reload_ff[15:8] <= s_axi_wdata[15:8];
					end
					OFF_MASK:
						if (s_axi_wstrb[0])
							mask_ff <= s_axi_wdata[ST_W-1:0];
					OFF_SERVICE, OFF_COUNT, OFF_STATUS, OFF_MGMT:
						s_axi_bresp <= RESP_OKAY;
					default:
						s_axi_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				unique case (s_axi_araddr)
					OFF_CTRL:    s_axi_rdata <= {24'h000000, ctrl_ff};
					OFF_RELOAD:  s_axi_rdata <= {16'h0000, reload_ff};
					OFF_SERVICE: s_axi_rdata <= 32'h00000000;
					OFF_COUNT:   s_axi_rdata <= {16'h0000, count_ff};
					OFF_STATUS:  s_axi_rdata <= {24'h000000, status_ff};
					OFF_MASK:    s_axi_rdata <= {24'h000000, mask_ff};
					OFF_MGMT:    s_axi_rdata <= {27'h0000000, min_mult_sel, boot_ff == BOOT_OK,
						first_exp_ff, sync2_ff[11:10]};
					default:     s_axi_rresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	first_smi_a: assert property (expire && !first_exp_ff && !svc_wr |=> system_mgmt_interrupt && first_exp_ff)
		else $error("first expiry gave no interrupt");
	second_rst_a: assert property (expire && first_exp_ff && !svc_wr |=> sys_reset_out && !first_exp_ff)
		else $error("second expiry gave no reset");
	service_cancel_a: assert property (svc_wr |=> !first_exp_ff && count_ff == $past(reload_ff))
		else $error("service did not reload timer");
	boot_seen_a: assert property (boot_ff == BOOT_WAIT && fetch_seen |=> boot_ff == BOOT_OK)
		else $error("fetch not recognised");
	boot_fail_a: assert property (reboot |=> sys_reset_out && min_mult_sel && boot_ff == BOOT_WAIT)
		else $error("failed boot did not reboot slow");
	intr_sel_a: assert property (intr_edge |=> lockup_watch_irq == $past(ctrl_ff[CTRL_INTR_LW])
		&& (system_mgmt_interrupt || $past(ctrl_ff[CTRL_INTR_LW])))
		else $error("case open routed wrongly");
	decode_gate_a: assert property (func_decode_en != '0 |-> ($past(func_decode_hit) & ~$past(fdis)) == func_decode_en)
		else $error("disabled function decoded");
	irq_gate_a: assert property (fdis == '1 ##1 fdis == '1 |-> !func_irq_out && !func_pme_out)
		else $error("disabled function raised event");
	ecc_route_a: assert property (ecc_edge && sync2_ff[7:6] == ECC_SERR |=> serr_out && !acpi_control_interrupt)
		else $error("memory error message misrouted");
	alert_send_a: assert property (lw_event && link_ff == LINK_IDLE |=> link_ff == LINK_SEND)
		else $error("alert message not started");
	mgmt_view_a: assert property (sync2_ff[9:8] == 2'h1 |=> mgmt_rd_data == $past(count_ff))
		else $error("management view wrong");
	irq_level_a: assert property (##1 irq == |($past(status_ff) & $past(mask_ff)))
		else $error("interrupt level wrong");
endmodule

// ---- verification/lwm_mc_model.sv ----
// Behavioural model of the external management microcontroller on the management bus
`timescale 1ns/10ps
module lwm_mc_model (
	// Clock
	input  wire logic        core_clk,
	// Management bus slave view
	input  wire logic [15:0] mgmt_rd_data,
	output logic      [1:0]  mgmt_sel,
	output logic             mgmt_reset_req,
	output logic             mgmt_msg_req
);
	initial
	begin
		mgmt_sel       = 2'h0;
		mgmt_reset_req = 1'b0;
		mgmt_msg_req   = 1'b0;
	end

	// The view is registered behind a sync chain, so wait before sampling it
	task view(input logic [1:0] sel, output logic [15:0] data);
		@(posedge core_clk);
		mgmt_sel <= sel;
		repeat (5) @(posedge core_clk);
		data = mgmt_rd_data;
	endtask

	// Requests are asynchronous pins: hold them long enough for the sync chain
	task request(input logic is_msg);
		@(posedge core_clk);
		mgmt_msg_req   <= is_msg;
		mgmt_reset_req <= !is_msg;
		repeat (4) @(posedge core_clk);
		mgmt_msg_req   <= 1'b0;
		mgmt_reset_req <= 1'b0;
	endtask
endmodule

// ---- verification/tb_lockup_watchdog_manageability.sv ----
// Self-checking testbench for the lockup watchdog manageability block
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_lockup_watchdog_manageability;
	import lwm_pkg::*;
	logic core_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, ecc_msg_code, sys_power_state, mgmt_sel;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic case_open_n, thermal_event, first_fetch, ecc_msg_valid, mgmt_reset_req, mgmt_msg_req;
	logic [15:0] mgmt_rd_data, link_sh, link_last, view_d;
	logic [4:0] func_decode_hit, func_irq, func_pme, func_decode_en, dis;
	logic func_irq_out, func_pme_out, system_mgmt_interrupt, acpi_control_interrupt, serr_out;
	logic lockup_watch_irq, sys_reset_out, gpio_blink, min_mult_sel, irq, blink_prev;
	logic mgmt_side_link_clk, mgmt_side_link_data;
	logic [31:0] rdat;
	int fail_count, checks, seed, i, c, words, nbit, w0;
	int cnt[6];

	lwm_top #(.BOOT_TICKS(2), .BLINK_TICKS(2), .BLINK_TOGGLES(2)) dut_u (.core_clk, .reset,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .case_open_n,
		.thermal_event, .first_fetch, .ecc_msg_valid, .ecc_msg_code, .sys_power_state, .mgmt_sel,
		.mgmt_reset_req, .mgmt_msg_req, .mgmt_rd_data, .func_decode_hit, .func_irq, .func_pme,
		.func_decode_en, .func_irq_out, .func_pme_out, .system_mgmt_interrupt, .acpi_control_interrupt,
		.serr_out, .lockup_watch_irq, .sys_reset_out, .gpio_blink, .min_mult_sel, .irq,
		.mgmt_side_link_clk, .mgmt_side_link_data);
	lwm_mc_model mc_u (.core_clk, .mgmt_rd_data, .mgmt_sel, .mgmt_reset_req, .mgmt_msg_req);

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Pulse counters: 0 mgmt int, 1 acpi, 2 serr, 3 lockup irq, 4 system reset, 5 blink toggles
	always @(posedge core_clk)
	begin
		cnt[0] += system_mgmt_interrupt;
		cnt[1] += acpi_control_interrupt;
		cnt[2] += serr_out;
		cnt[3] += lockup_watch_irq;
		cnt[4] += sys_reset_out;
		cnt[5] += (gpio_blink !== blink_prev);
		blink_prev = gpio_blink;
	end

	// Side link receiver samples on the rising link clock, msb first
	always @(posedge mgmt_side_link_clk)
	begin
		link_sh = {link_sh[14:0], mgmt_side_link_data};
		nbit++;
		if (nbit == 16)
		begin
			words++;
			link_last = link_sh;
			nbit = 0;
		end
	end

	task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!got)
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				got = 1'b1;
				`CHK(s_axi_bresp, er)
			end
		end
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		while (!got)
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				got = 1'b1;
				d = s_axi_rdata;
				`CHK(s_axi_rresp, er)
			end
		end
		s_axi_rready <= 1'b0;
	endtask

	// A memory hub message drives only the output whose code it carries
	function automatic int ecc_hits(input int code, input int route);
		return int'(code == route);
	endfunction

	task conclude;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge core_clk);
		fail_count++;
		conclude;
	end

	initial
	begin
		seed = 63;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{thermal_event, first_fetch, ecc_msg_valid, ecc_msg_code} = '0;
		{func_decode_hit, func_irq, func_pme, nbit, words} = '0;
		case_open_n = 1'b1;
		blink_prev = 1'b0;
		sys_power_state = 2'h0;
		cnt = '{default: 0};
		reset = 1'b1;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		// Reset values, unmapped access, write to a read-only place
		rd(OFF_CTRL, rdat, RESP_OKAY);
		`CHK(rdat[7:0], CTRL_RST)
		rd(OFF_RELOAD, rdat, RESP_OKAY);
		`CHK(rdat[15:0], RELOAD_RST)
		rd(5'h1c, rdat, RESP_SLVERR);
		`CHK(rdat, 32'h0)
		wr(5'h1c, 32'hff, RESP_SLVERR);
		wr(OFF_COUNT, 32'h0, RESP_OKAY);
		$display("test registers done");
		// No first fetch: blink, reboot at low multiplier, alert on the link
		for (i = 0; i < 4000 && min_mult_sel !== 1'b1; i++) @(posedge core_clk);
		first_fetch <= 1'b1;
		`CHK(min_mult_sel, 1'b1)
		repeat (400) @(posedge core_clk);
		`CHK(cnt[5], 2)
		`CHK(words, 1)
		`CHK(link_last, ALERT_MSG)
		rd(OFF_STATUS, rdat, RESP_OKAY);
		`CHK(rdat[ST_NO_BOOT], 1'b1)
		$display("test boot monitor done");
		// Two-stage timer with a service between expiries
		wr(OFF_RELOAD, 32'h2, RESP_OKAY);
		wr(OFF_SERVICE, 32'h0, RESP_OKAY);
		cnt = '{default: 0};
		for (i = 0; i < 1500 && cnt[0] == 0; i++) @(posedge core_clk);
		`CHK(cnt[0], 1)
		`CHK(cnt[4], 0)
		wr(OFF_SERVICE, 32'h0, RESP_OKAY);
		repeat (300) @(posedge core_clk);
		`CHK(cnt[4], 0)
		for (i = 0; i < 2000 && cnt[4] == 0; i++) @(posedge core_clk);
		`CHK(cnt[4], 1)
		`CHK(cnt[0], 2)
		rd(OFF_STATUS, rdat, RESP_OKAY);
		`CHK(rdat[1:0], 2'h3)
		wr(OFF_CTRL, 32'h4, RESP_OKAY);
		$display("test timer done");
		// Case open routed each way, then a thermal event
		w0 = words;
		for (c = 0; c < 2; c++)
		begin
			wr(OFF_CTRL, 32'h4 | (c << CTRL_INTR_LW), RESP_OKAY);
			cnt = '{default: 0};
			case_open_n <= 1'b0;
			repeat (10) @(posedge core_clk);
			case_open_n <= 1'b1;
			repeat (400) @(posedge core_clk);
			`CHK(cnt[0], 1 - c)
			`CHK(cnt[3], c)
		end
		`CHK(words, w0 + 1)
		thermal_event <= 1'b1;
		repeat (400) @(posedge core_clk);
		thermal_event <= 1'b0;
		`CHK(words, w0 + 2)
		`CHK(link_last, ALERT_MSG)
		$display("test case open done");
		// Every memory hub message code
		for (c = 0; c < 4; c++)
		begin
			cnt = '{default: 0};
			ecc_msg_code <= c[1:0];
			repeat (4) @(posedge core_clk);
			ecc_msg_valid <= 1'b1;
			repeat (8) @(posedge core_clk);
			ecc_msg_valid <= 1'b0;
			`CHK(cnt[0], ecc_hits(c, ECC_SMI))
			`CHK(cnt[1], ecc_hits(c, ECC_ACPI))
			`CHK(cnt[2], ecc_hits(c, ECC_SERR))
		end
		$display("test memory messages done");
		// Random function disables against random traffic
		for (i = 0; i < 20; i++)
		begin
			dis = $random(seed);
			if (i == 0)
				dis = 5'h1f;
			wr(OFF_CTRL, {dis, 3'h4}, RESP_OKAY);
			repeat (4)
			begin
				@(posedge core_clk);
				{func_decode_hit, func_irq, func_pme} <= $random(seed);
				@(posedge core_clk);
				#1;
				`CHK(func_decode_en, func_decode_hit & ~dis)
				`CHK(func_irq_out, |(func_irq & ~dis))
				`CHK(func_pme_out, |(func_pme & ~dis))
			end
		end
		$display("test function disable done");
		// Management controller: views, reset and message requests, masked interrupt
		sys_power_state <= $random(seed);
		wr(OFF_CTRL, 32'h4, RESP_OKAY);
		mc_u.view(2'h0, view_d);
		`CHK(view_d[1:0], sys_power_state)
		mc_u.view(2'h1, view_d);
		`CHK(view_d, 16'h0002)
		mc_u.view(2'h3, view_d);
		`CHK(view_d[2:0], 3'h6)
		rd(OFF_MGMT, rdat, RESP_OKAY);
		`CHK(rdat[4:0], {3'h6, sys_power_state})
		wr(OFF_MASK, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, rdat, RESP_OKAY);
		cnt = '{default: 0};
		mc_u.request(1'b0);
		mc_u.request(1'b1);
		repeat (8) @(posedge core_clk);
		`CHK(cnt[4], 1)
		`CHK(irq, 1'b0)
		wr(OFF_MASK, 32'h1 << ST_MGMT_MSG, RESP_OKAY);
		repeat (3) @(posedge core_clk);
		`CHK(irq, 1'b1)
		mc_u.view(2'h2, view_d);
		`CHK(view_d[7:6], 2'h3)
		rd(OFF_STATUS, rdat, RESP_OKAY);
		`CHK(rdat[7:6], 2'h3)
		repeat (3) @(posedge core_clk);
		`CHK(irq, 1'b0)
		$display("test management view done");
		conclude;
	end
endmodule
